/* File: src/tsc_map.svh */
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

// register offsets on the serial register port
`define TSC_OFF_LINK_MODES 8'h00
`define TSC_OFF_SIDE_MODES 8'h01
`define TSC_OFF_RX_SET 8'h10
`define TSC_OFF_PULSE_LO 8'h11
`define TSC_OFF_PULSE_HI 8'h12
`define TSC_OFF_EQ_LO 8'h13
`define TSC_OFF_EQ_HI 8'h14
`define TSC_OFF_DRV_SET 8'h20

// reset values
`define TSC_RST_LINK_MODES 8'h40
`define TSC_RST_SIDE_MODES 8'h40
`define TSC_RST_RX_SET 8'h01
`define TSC_RST_PULSE 8'h00
`define TSC_RST_EQ 8'h00
`define TSC_RST_DRV_SET 8'h03

// writable bits per register
`define TSC_MASK_MODES 8'h43
`define TSC_MASK_RX_SET 8'h01
`define TSC_MASK_DRV_SET 8'h0F

// field positions
`define TSC_BIT_ENABLE 6
`define TSC_BIT_SRC_HI 1
`define TSC_BIT_SRC_LO 0
`define TSC_BIT_RX_TERM 0
`define TSC_BIT_PE_HI 3
`define TSC_BIT_PE_LO 2
`define TSC_BIT_OUT_TERM 1
`define TSC_BIT_OUT_CUR 0

// termination pulse timing
`define TSC_PULSE_MS 100
`define TSC_CLK_HZ 100000000
`define TSC_PULSE_CYCLES (`TSC_PULSE_MS * (`TSC_CLK_HZ / 1000))
`define TSC_CNT_W 24

`endif

/* File: src/tsc_pkg.sv */
package tsc_pkg;

   // configuration source of the register image
   typedef enum logic [1:0] {
      tsc_mode_parallel = 2'b01,
      tsc_mode_serial = 2'b10
   } tsc_mode_t;

   // high speed and auxiliary source codes
   typedef enum logic [1:0] {
      tsc_src_a = 2'b00,
      tsc_src_b = 2'b01,
      tsc_src_c = 2'b10,
      tsc_src_d = 2'b11
   } tsc_src_t;

endpackage : tsc_pkg

/* File: src/tsc_pulse_timer.sv */
`timescale 1ns/1ps
`include "tsc_map.svh"

module tsc_pulse_timer #(
   parameter int unsigned CYCLES = `TSC_PULSE_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic start,
   output logic active
);

   localparam logic [`TSC_CNT_W-1:0] LOAD = CYCLES[`TSC_CNT_W-1:0];

   logic [`TSC_CNT_W-1:0] count_r;
   logic [`TSC_CNT_W-1:0] count_nxt;

   // restart wins over the running count
   assign count_nxt = start ? LOAD :
                      (count_r != '0) ? count_r - 1'b1 : count_r;
   assign active = (count_r != '0);

   // cycle counter of the disconnect interval
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

   timer_reload_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      start |=> (count_r == LOAD) && active)
      else $error("pulse timer did not reload on start");

endmodule : tsc_pulse_timer

/* File: src/tsc_config.sv */
// How it works
// - channels with a pulse bit set lose input termination for 100 ms after a source switch.
// - pulse bits 0-3 B0-B3, 4-7 A0-A3, 8-11 C3-C0, 12-15 D3-D0.
// - each equalization bit picks 6 dB when 0, 12 dB when 1.
// - two-bit pre-emphasis for all outputs: 0, 2, 4 or 6 dB.
// - output termination bit turns all output terminations off or on.
// - output current bit selects 10 mA or 20 mA for all channels.
// - strap pins count only from reset until the first serial access.
// - strap enable low gives standby with link off; high turns link on.
// - strap source code 00..11 routes link source A..D to the output.
// - strap mode keeps the auxiliary switch enabled; its enable reads 1.
// - same strap code routes auxiliary source A..D to the common port.
// - strap mode keeps input terminations on; its bit reads 1.
// - strap mode forces both pulse registers to zero.
// - strap equalization pin copied to all sixteen equalization bits.
// - strap driver image: pre-emphasis bits 3:2, termination 1, current 0.
// - mode images: enable bit 6, source bits 1:0, bits 5:2 zero.
// - input termination enable 0 turns all off; 1 on, subject to pulsing.
`timescale 1ns/1ps
`include "tsc_map.svh"

module tsc_config #(
   parameter int unsigned PULSE_CYCLES = `TSC_PULSE_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic strap_link_enable,
   input wire logic [1:0] strap_source_select,
   input wire logic strap_eq_level,
   input wire logic [1:0] strap_preemph_pins,
   input wire logic strap_out_term,
   input wire logic strap_out_current,
   output logic parallel_mode,
   output logic link_enable,
   output logic standby,
   output logic [1:0] hs_source,
   output logic aux_enable,
   output logic [1:0] aux_source,
   output logic input_term_enable,
   output logic [15:0] term_connected,
   output logic [15:0] input_eq_select,
   output logic [1:0] out_preemph_level,
   output logic out_term_enable,
   output logic out_current_select,
   output logic term_pulse_active
);

   tsc_pkg::tsc_mode_t mode_r;
   tsc_pkg::tsc_mode_t mode_nxt;

   // strap synchronisers: first stage read only by second
   logic [7:0] strap_meta_r;
   logic [7:0] strap_sync_r;
   wire [7:0] strap_raw = {strap_link_enable, strap_source_select, strap_eq_level,
                           strap_preemph_pins, strap_out_term, strap_out_current};

   // register storage
   logic [7:0] link_modes_r;
   logic [7:0] side_modes_r;
   logic [7:0] rx_set_r;
   logic [7:0] pulse_lo_r;
   logic [7:0] pulse_hi_r;
   logic [7:0] eq_lo_r;
   logic [7:0] eq_hi_r;
   logic [7:0] drv_set_r;
   logic [7:0] link_modes_nxt;
   logic [7:0] side_modes_nxt;
   logic [7:0] rx_set_nxt;
   logic [7:0] pulse_lo_nxt;
   logic [7:0] pulse_hi_nxt;
   logic [7:0] eq_lo_nxt;
   logic [7:0] eq_hi_nxt;
   logic [7:0] drv_set_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [1:0] prev_src_r;
   logic [15:0] term_conn_r;
   logic [15:0] term_conn_nxt;
   logic pulse_active;

   // synced strap fields
   wire s_en = strap_sync_r[7];
   wire [1:0] s_src = strap_sync_r[6:5];
   wire s_eq = strap_sync_r[4];
   wire [1:0] s_pe = strap_sync_r[3:2];
   wire s_oto = strap_sync_r[1];
   wire s_ocl = strap_sync_r[0];

   // mode decode
   wire is_par = (mode_r == tsc_pkg::tsc_mode_parallel);
   wire access = reg_wr | reg_rd;

   // strap register image
   wire [7:0] img_link = {1'b0, s_en, 4'h0, s_src};
   wire [7:0] img_side = {1'b0, 1'b1, 4'h0, s_src};
   wire [7:0] img_rx = 8'h01;
   wire [7:0] img_pulse = 8'h00;
   wire [7:0] img_eq = {8{s_eq}};
   wire [7:0] img_drv = {4'h0, s_pe, s_oto, s_ocl};

   // write strobes per register
   wire wr_link = reg_wr && (reg_addr == `TSC_OFF_LINK_MODES);
   wire wr_side = reg_wr && (reg_addr == `TSC_OFF_SIDE_MODES);
   wire wr_rx = reg_wr && (reg_addr == `TSC_OFF_RX_SET);
   wire wr_plo = reg_wr && (reg_addr == `TSC_OFF_PULSE_LO);
   wire wr_phi = reg_wr && (reg_addr == `TSC_OFF_PULSE_HI);
   wire wr_elo = reg_wr && (reg_addr == `TSC_OFF_EQ_LO);
   wire wr_ehi = reg_wr && (reg_addr == `TSC_OFF_EQ_HI);
   wire wr_drv = reg_wr && (reg_addr == `TSC_OFF_DRV_SET);

   // base value: strap image while strapped, stored value after
   wire [7:0] b_link = is_par ? img_link : link_modes_r;
   wire [7:0] b_side = is_par ? img_side : side_modes_r;
   wire [7:0] b_rx = is_par ? img_rx : rx_set_r;
   wire [7:0] b_plo = is_par ? img_pulse : pulse_lo_r;
   wire [7:0] b_phi = is_par ? img_pulse : pulse_hi_r;
   wire [7:0] b_elo = is_par ? img_eq : eq_lo_r;
   wire [7:0] b_ehi = is_par ? img_eq : eq_hi_r;
   wire [7:0] b_drv = is_par ? img_drv : drv_set_r;

   // the first access writes on top of the strap image
   assign link_modes_nxt = wr_link ? (reg_wdata & `TSC_MASK_MODES) : b_link;
   assign side_modes_nxt = wr_side ? (reg_wdata & `TSC_MASK_MODES) : b_side;
   assign rx_set_nxt = wr_rx ? (reg_wdata & `TSC_MASK_RX_SET) : b_rx;
   assign pulse_lo_nxt = wr_plo ? reg_wdata : b_plo;
   assign pulse_hi_nxt = wr_phi ? reg_wdata : b_phi;
   assign eq_lo_nxt = wr_elo ? reg_wdata : b_elo;
   assign eq_hi_nxt = wr_ehi ? reg_wdata : b_ehi;
   assign drv_set_nxt = wr_drv ? (reg_wdata & `TSC_MASK_DRV_SET) : b_drv;

   // any serial access ends strap mode for good
   assign mode_nxt = (is_par && access) ? tsc_pkg::tsc_mode_serial : mode_r;

   // read data select, unmapped reads give zero
   assign rdata_nxt =
      !reg_rd ? rdata_r :
      (reg_addr == `TSC_OFF_LINK_MODES) ? link_modes_r :
      (reg_addr == `TSC_OFF_SIDE_MODES) ? side_modes_r :
      (reg_addr == `TSC_OFF_RX_SET) ? rx_set_r :
      (reg_addr == `TSC_OFF_PULSE_LO) ? pulse_lo_r :
      (reg_addr == `TSC_OFF_PULSE_HI) ? pulse_hi_r :
      (reg_addr == `TSC_OFF_EQ_LO) ? eq_lo_r :
      (reg_addr == `TSC_OFF_EQ_HI) ? eq_hi_r :
      (reg_addr == `TSC_OFF_DRV_SET) ? drv_set_r : 8'h00;

   // strap pin synchroniser
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         strap_meta_r <= 8'h00;
         strap_sync_r <= 8'h00;
      end else begin
         strap_meta_r <= strap_raw;
         strap_sync_r <= strap_meta_r;
      end
   end

   // mode state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= tsc_pkg::tsc_mode_parallel;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // configuration registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         link_modes_r <= `TSC_RST_LINK_MODES;
         side_modes_r <= `TSC_RST_SIDE_MODES;
         rx_set_r <= `TSC_RST_RX_SET;
         pulse_lo_r <= `TSC_RST_PULSE;
         pulse_hi_r <= `TSC_RST_PULSE;
         eq_lo_r <= `TSC_RST_EQ;
         eq_hi_r <= `TSC_RST_EQ;
         drv_set_r <= `TSC_RST_DRV_SET;
      end else begin
         link_modes_r <= link_modes_nxt;
         side_modes_r <= side_modes_nxt;
         rx_set_r <= rx_set_nxt;
         pulse_lo_r <= pulse_lo_nxt;
         pulse_hi_r <= pulse_hi_nxt;
         eq_lo_r <= eq_lo_nxt;
         eq_hi_r <= eq_hi_nxt;
         drv_set_r <= drv_set_nxt;
      end
   end

   // read data and source history
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
         prev_src_r <= 2'b00;
         term_conn_r <= 16'h0000;
      end else begin
         rdata_r <= rdata_nxt;
         prev_src_r <= link_modes_r[`TSC_BIT_SRC_HI:`TSC_BIT_SRC_LO];
         term_conn_r <= term_conn_nxt;
      end
   end

   // source switch restarts the disconnect interval
   wire src_change = (link_modes_r[`TSC_BIT_SRC_HI:`TSC_BIT_SRC_LO] != prev_src_r);

   tsc_pulse_timer #(
      .CYCLES(PULSE_CYCLES)
   ) u_timer (
      .clock(clock),
      .rst_n(rst_n),
      .start(src_change),
      .active(pulse_active)
   );

   wire [15:0] pulse_sel = {pulse_hi_r, pulse_lo_r};
   wire rx_term_on = rx_set_r[`TSC_BIT_RX_TERM];

   // per channel termination, index = source*4 + lane
   for (genvar i = 0; i < 16; i++) begin : g_term
      localparam int SRC = i / 4;
      localparam int LANE = i % 4;
      localparam int PBIT = (SRC == 0) ? 4 + LANE :
                            (SRC == 1) ? LANE :
                            (SRC == 2) ? 11 - LANE : 15 - LANE;
      assign term_conn_nxt[i] = rx_term_on &&
                                !(pulse_active && pulse_sel[PBIT]);
   end

   // outputs
   assign reg_rdata = rdata_r;
   assign parallel_mode = is_par;
   assign link_enable = link_modes_r[`TSC_BIT_ENABLE];
   assign standby = !link_modes_r[`TSC_BIT_ENABLE];
   assign hs_source = link_modes_r[`TSC_BIT_SRC_HI:`TSC_BIT_SRC_LO];
   assign aux_enable = side_modes_r[`TSC_BIT_ENABLE];
   assign aux_source = side_modes_r[`TSC_BIT_SRC_HI:`TSC_BIT_SRC_LO];
   assign input_term_enable = rx_term_on;
   assign term_connected = term_conn_r;
   assign input_eq_select = {eq_hi_r, eq_lo_r};
   assign out_preemph_level = drv_set_r[`TSC_BIT_PE_HI:`TSC_BIT_PE_LO];
   assign out_term_enable = drv_set_r[`TSC_BIT_OUT_TERM];
   assign out_current_select = drv_set_r[`TSC_BIT_OUT_CUR];
   assign term_pulse_active = pulse_active;

   // helper: cycles of the current pulse since its last restart
   logic [`TSC_CNT_W-1:0] run_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run_r <= '0;
      end else begin
         run_r <= (src_change || !pulse_active) ? '0 : run_r + 1'b1;
      end
   end

   mode_one_way_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      !is_par |=> !is_par)
      else $error("strap mode came back after serial access");

   first_access_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      is_par && access |=> !is_par)
      else $error("first access did not leave strap mode");

   strap_link_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      is_par && $past(is_par) && $past(rst_n)
         |-> link_enable == $past(s_en) && standby != link_enable)
      else $error("link enable does not follow strap");

   strap_aux_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      is_par && $past(is_par) |-> aux_enable && aux_source == $past(s_src)
                                   && hs_source == $past(s_src))
      else $error("auxiliary image wrong in strap mode");

   strap_pulse_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      is_par && $past(is_par) |-> pulse_sel == 16'h0000 && input_term_enable)
      else $error("pulse bits not forced in strap mode");

   strap_eq_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      is_par && $past(is_par) |-> input_eq_select == {16{$past(s_eq)}})
      else $error("equalization not copied from strap");

   term_off_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      !rx_term_on |=> term_connected == 16'h0000)
      else $error("termination connected while disabled");

   pulse_length_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      run_r <= PULSE_CYCLES[`TSC_CNT_W-1:0])
      else $error("disconnect interval too long");

   pulse_start_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      src_change |=> pulse_active)
      else $error("source change did not start interval");

   drv_image_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      drv_set_r[7:4] == 4'h0 && link_modes_r[5:2] == 4'h0 && side_modes_r[5:2] == 4'h0)
      else $error("reserved image bits not zero");

   // termination follows the pulse map while enabled
   term_map_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      rx_term_on && pulse_active |=> term_connected[4] == !$past(pulse_sel[0])
         && term_connected[0] == !$past(pulse_sel[4])
         && term_connected[11] == !$past(pulse_sel[8])
         && term_connected[15] == !$past(pulse_sel[12]))
      else $error("pulse bit drives the wrong channel");

   term_kept_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      rx_term_on && !pulse_active |=> term_connected == 16'hFFFF)
      else $error("termination open outside the interval");

   pulse_end_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      run_r == PULSE_CYCLES[`TSC_CNT_W-1:0] |-> !pulse_active)
      else $error("disconnect interval did not end on time");

   // register image checks
   strap_drv_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      is_par && $past(is_par) && $past(rst_n)
         |-> drv_set_r == {4'h0, $past(s_pe), $past(s_oto), $past(s_ocl)})
      else $error("driver image does not follow strap");

   serial_hold_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      !is_par && !reg_wr |=> $stable(link_modes_r) && $stable(side_modes_r)
         && $stable(drv_set_r))
      else $error("register changed without a write");

   write_mask_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      reg_wr && reg_addr == `TSC_OFF_LINK_MODES
         |=> link_modes_r == ($past(reg_wdata) & `TSC_MASK_MODES))
      else $error("link mode write not masked");

endmodule : tsc_config

/* File: tb/tsc_ctrl_model.sv */
`timescale 1ns/1ps

module tsc_ctrl_model (
   input wire logic clock,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   output logic strap_link_enable,
   output logic [1:0] strap_source_select,
   output logic strap_eq_level,
   output logic [1:0] strap_preemph_pins,
   output logic strap_out_term,
   output logic strap_out_current
);
   // quiet port and low straps from time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      set_straps(8'h00);
   end

   // straps are whole static levels: en, src[1:0], eq, pe[1:0], term, current
   task automatic set_straps(input logic [7:0] v);
      {strap_link_enable, strap_source_select, strap_eq_level} = v[7:4];
      {strap_preemph_pins, strap_out_term, strap_out_current} = v[3:0];
   endtask : set_straps

   // one strobe cycle; released address and data are scrambled
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(negedge clock);
      reg_addr = addr;
      reg_wdata = data;
      reg_wr = wr;
      reg_rd = !wr;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~addr;
      reg_wdata = ~data;
   endtask : access

   // read data is settled at the falling edge after the sampling edge
   task automatic read(input logic [7:0] addr, output logic [7:0] data);
      access(1'b0, addr, 8'h00);
      data = reg_rdata;
   endtask : read
endmodule : tsc_ctrl_model

/* File: tb/tsc_config_bench.sv */
`timescale 1ns/1ps
`include "tsc_map.svh"

module tsc_config_bench;
   localparam int PULSE = 20;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, hs, aux, rx, drv, v, d;
   logic reg_wr, reg_rd, s_en, s_eq, s_ot, s_oc;
   logic [1:0] s_src, s_pe, hs_source, aux_source, out_preemph_level;
   logic parallel_mode, link_enable, standby, aux_enable, input_term_enable;
   logic out_term_enable, out_current_select, term_pulse_active;
   logic [15:0] term_connected, input_eq_select, pulse, eq;
   logic [15:0] lfsr = 16'h43AD;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int n;

   always #5 clock = ~clock;

   tsc_ctrl_model u_ctrl (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_link_enable(s_en),
      .strap_source_select(s_src), .strap_eq_level(s_eq), .strap_preemph_pins(s_pe),
      .strap_out_term(s_ot), .strap_out_current(s_oc));

   tsc_config #(.PULSE_CYCLES(PULSE)) u_dut (.clock(clock), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .strap_link_enable(s_en), .strap_source_select(s_src),
      .strap_eq_level(s_eq), .strap_preemph_pins(s_pe), .strap_out_term(s_ot),
      .strap_out_current(s_oc), .parallel_mode(parallel_mode), .link_enable(link_enable),
      .standby(standby), .hs_source(hs_source), .aux_enable(aux_enable),
      .aux_source(aux_source), .input_term_enable(input_term_enable),
      .term_connected(term_connected), .input_eq_select(input_eq_select),
      .out_preemph_level(out_preemph_level), .out_term_enable(out_term_enable),
      .out_current_select(out_current_select), .term_pulse_active(term_pulse_active));

   function automatic logic [15:0] next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : next

   // expected termination per channel, index source*4+lane
   function automatic logic [15:0] conn(input logic act);
      logic [15:0] m;
      m = 16'h0000;
      for (int i = 0; i < 4; i++) begin
         m[4 + i] = pulse[i];
         m[i] = pulse[4 + i];
         m[11 - i] = pulse[8 + i];
         m[15 - i] = pulse[12 + i];
      end
      if (!rx[0]) return 16'h0000;
      return act ? ~m : 16'hFFFF;
   endfunction : conn

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // all configuration outputs against the bench image
   task automatic check_cfg(input logic par);
      check("parallel_mode", 16'(parallel_mode), 16'(par));
      check("link_enable", 16'(link_enable), 16'(hs[6]));
      check("standby", 16'(standby), 16'(!hs[6]));
      check("hs_source", 16'(hs_source), 16'(hs[1:0]));
      check("aux_enable", 16'(aux_enable), 16'(aux[6]));
      check("aux_source", 16'(aux_source), 16'(aux[1:0]));
      check("input_term_enable", 16'(input_term_enable), 16'(rx[0]));
      check("term_connected", term_connected, conn(1'b0));
      check("input_eq_select", input_eq_select, eq);
      check("out_preemph_level", 16'(out_preemph_level), 16'(drv[3:2]));
      check("out_term_enable", 16'(out_term_enable), 16'(drv[1]));
      check("out_current_select", 16'(out_current_select), 16'(drv[0]));
   endtask : check_cfg

   // register images read back through the port
   task automatic check_regs();
      logic [7:0] r;
      u_ctrl.read(`TSC_OFF_LINK_MODES, r);
      check("link_modes", 16'(r), 16'(hs));
      u_ctrl.read(`TSC_OFF_SIDE_MODES, r);
      check("side_modes", 16'(r), 16'(aux));
      u_ctrl.read(`TSC_OFF_RX_SET, r);
      check("rx_settings", 16'(r), 16'(rx));
      u_ctrl.read(`TSC_OFF_PULSE_LO, r);
      check("pulse_lo", 16'(r), 16'(pulse[7:0]));
      u_ctrl.read(`TSC_OFF_PULSE_HI, r);
      check("pulse_hi", 16'(r), 16'(pulse[15:8]));
      u_ctrl.read(`TSC_OFF_EQ_LO, r);
      check("eq_lo", 16'(r), 16'(eq[7:0]));
      u_ctrl.read(`TSC_OFF_EQ_HI, r);
      check("eq_hi", 16'(r), 16'(eq[15:8]));
      u_ctrl.read(`TSC_OFF_DRV_SET, r);
      check("driver_settings", 16'(r), 16'(drv));
   endtask : check_regs

   task automatic summarize();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   // hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         summarize();
      end
   end

   initial begin
      // strap mode with a random image and its inverse
      lfsr = next(lfsr);
      v = lfsr[7:0];
      for (n = 0; n < 2; n++) begin
         // straps move at a falling edge, after the model's time-zero defaults
         @(negedge clock);
         u_ctrl.set_straps(v);
         rst_n = 1'b0;
         repeat (4) @(posedge clock);
         @(negedge clock) rst_n = 1'b1;
         hs = {1'b0, v[7], 4'h0, v[6:5]};
         aux = {2'b01, 4'h0, v[6:5]};
         rx = 8'h01;
         pulse = 16'h0000;
         eq = {16{v[4]}};
         drv = {4'h0, v[3:0]};
         repeat (8) @(negedge clock);
         check_cfg(1'b1);
         check_regs();
         u_ctrl.set_straps(~v);
         repeat (6) @(negedge clock);
         check_cfg(1'b0);
         v = ~v;
      end
      // serial image, then a source change pulses selected terminations
      lfsr = next(lfsr);
      pulse = lfsr;
      lfsr = next(lfsr);
      eq = lfsr;
      lfsr = next(lfsr);
      drv = {4'h0, lfsr[3:0]};
      u_ctrl.access(1'b1, `TSC_OFF_PULSE_LO, pulse[7:0]);
      u_ctrl.access(1'b1, `TSC_OFF_PULSE_HI, pulse[15:8]);
      u_ctrl.access(1'b1, `TSC_OFF_EQ_LO, eq[7:0]);
      u_ctrl.access(1'b1, `TSC_OFF_EQ_HI, eq[15:8]);
      u_ctrl.access(1'b1, `TSC_OFF_DRV_SET, {4'hF, lfsr[3:0]});
      hs = {2'b01, 4'h0, ~hs[1:0]};
      u_ctrl.access(1'b1, `TSC_OFF_LINK_MODES, {6'h3F, hs[1:0]});
      for (n = 0; n < 10 && !term_pulse_active; n++) @(negedge clock);
      @(negedge clock);
      check("term_connected", term_connected, conn(1'b1));
      for (n = 1; n < 100 && term_pulse_active; n++) @(negedge clock);
      check("pulse_cycles", 16'(n), 16'(PULSE));
      repeat (2) @(negedge clock);
      check_cfg(1'b0);
      check_regs();
      // input terminations off, unmapped offset ignored
      rx = 8'h00;
      u_ctrl.access(1'b1, `TSC_OFF_RX_SET, 8'hFE);
      u_ctrl.access(1'b1, 8'h30, 8'h5A);
      u_ctrl.read(8'h30, d);
      check("unmapped", 16'(d), 16'h0000);
      // every driver code, source code and enable level
      for (n = 0; n < 16; n++) begin
         drv = 8'(n);
         aux = {1'b0, drv[3], 4'h0, drv[1:0]};
         hs = {1'b0, drv[2], 4'h0, drv[1:0]};
         u_ctrl.access(1'b1, `TSC_OFF_DRV_SET, drv);
         u_ctrl.access(1'b1, `TSC_OFF_SIDE_MODES, aux | 8'h3C);
         u_ctrl.access(1'b1, `TSC_OFF_LINK_MODES, hs);
         @(negedge clock);
         check_cfg(1'b0);
      end
      summarize();
   end
endmodule : tsc_config_bench
